/* File: design/suac_pkg.sv */
// shared constants and types for the suspend aware clock output block
package suac_pkg;
   // system clock and clock synthesis
   localparam int CLK_MHZ        = 250;
   localparam int CLK_HZ         = CLK_MHZ * 1_000_000;
   localparam int REF_MHZ        = 6;
   localparam int PLL_MULT       = 8;
   localparam int PLL_MHZ        = REF_MHZ * PLL_MULT;
   localparam int ACC_W          = 9;
   localparam logic [ACC_W-1:0] ACC_MOD = ACC_W'(CLK_MHZ);
   localparam logic [ACC_W-1:0] ACC_INC = ACC_W'(2 * PLL_MHZ);
   localparam int DIV_W          = 4;
   localparam int DIV_STEPS      = 2 ** DIV_W;
   // slow low power clock, half period in system cycles
   localparam int LAZY_HZ        = 100_000;
   localparam int LAZY_HALF_CYC  = CLK_HZ / (2 * LAZY_HZ);
   localparam int LAZY_W         = 11;
   localparam logic [LAZY_W-1:0] LAZY_LAST = LAZY_W'(LAZY_HALF_CYC - 1);
   // suspend entry and resume delays
   localparam int SUSP_DELAY_US  = 2000;
   localparam int RES_DELAY_US   = 500;
   localparam int SUSP_DELAY_CYC = SUSP_DELAY_US * CLK_MHZ;
   localparam int RES_DELAY_CYC  = RES_DELAY_US * CLK_MHZ;
   localparam int TMR_W          = 19;
   // register bus
   localparam int ADDR_W         = 8;
   localparam int DATA_W         = 16;
   localparam logic [ADDR_W-1:0] REG_HW_CONFIG = 8'h00;
   localparam logic [ADDR_W-1:0] REG_DEV_MODE  = 8'h04;
   localparam logic [ADDR_W-1:0] REG_STATUS    = 8'h08;
   // field positions
   localparam int CFG_DIV_LSB    = 0;
   localparam int CFG_OSC_BIT    = 4;
   localparam int CFG_SLOW_BIT   = 5;
   localparam int MODE_SUSP_BIT  = 0;
   localparam int STS_SUSP_BIT   = 0;
   localparam int STS_OSC_BIT    = 1;
   localparam int STS_PLL_BIT    = 2;
   localparam int STS_LAZY_BIT   = 3;
   localparam int STS_STOP_BIT   = 4;
   // reset values
   localparam logic [DIV_W-1:0] CFG_DIV_RST = 4'h0;
   localparam logic             CFG_OSC_RST  = 1'b1;
   localparam logic             CFG_SLOW_RST = 1'b0;
   // output clock source
   typedef enum logic [1:0] {CKM_STOP, CKM_LAZY, CKM_NORMAL} suac_clkmode_t;
endpackage

/* File: design/suac_clkgen.sv */
// clock output generator: synthesised fast clock divider and slow clock
`timescale 1ns/100ps
module suac_clkgen
   import suac_pkg::*;
(
   // clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_sys_rst,
   // control
   input  wire suac_clkmode_t     i_mode,
   input  wire logic [DIV_W-1:0]  i_div,
   // clock output
   output logic                   o_clk_out
);
   localparam int NORM_GAP_MAX =
      (CLK_MHZ * DIV_STEPS + 2 * PLL_MHZ - 1) / (2 * PLL_MHZ);

   logic [ACC_W-1:0]  acc_r;
   logic [DIV_W-1:0]  tick_cnt_r;
   logic [LAZY_W-1:0] lazy_cnt_r;
   logic [ACC_W-1:0]  acc_sum;
   logic [ACC_W-1:0]  acc_nxt;
   logic              pll_tick;
   logic              div_hit;
   logic              lazy_hit;
   logic [DIV_W-1:0]  tick_cnt_nxt;
   logic [LAZY_W-1:0] lazy_cnt_nxt;
   logic              clk_nxt;

   // phase accumulator: ticks at twice the 48 MHz pll rate
   assign acc_sum  = acc_r + ACC_INC;                     // RL1
   assign pll_tick = (acc_sum >= ACC_MOD);                // RL1
   assign acc_nxt  = pll_tick ? acc_sum - ACC_MOD : acc_sum;

   // divide by field plus one, 48 MHz down to 3 MHz
   assign div_hit      = pll_tick && (tick_cnt_r >= i_div);   // RL2 RL3
   assign tick_cnt_nxt = !pll_tick ? tick_cnt_r :
                         div_hit   ? '0 : tick_cnt_r + 1'b1;

   // slow clock half period counter
   assign lazy_hit     = (lazy_cnt_r == LAZY_LAST);           // RL5
   assign lazy_cnt_nxt = lazy_hit ? '0 : lazy_cnt_r + 1'b1;

   // output source select, stop holds low
   assign clk_nxt = (i_mode == CKM_NORMAL) ? o_clk_out ^ div_hit :
                    (i_mode == CKM_LAZY)   ? o_clk_out ^ lazy_hit :
                    1'b0;                                     // RL10

   // counters and output flop
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         acc_r      <= '0;
         tick_cnt_r <= '0;
         lazy_cnt_r <= '0;
         o_clk_out  <= 1'b0;
      end
      else
      begin
         acc_r      <= acc_nxt;
         tick_cnt_r <= tick_cnt_nxt;
         lazy_cnt_r <= lazy_cnt_nxt;
         o_clk_out  <= clk_nxt;
      end
   end

   // helper: cycles since last output edge in steady normal mode
   logic [7:0] gap_r;
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst || i_mode != CKM_NORMAL || clk_nxt != o_clk_out ||
          i_div != $past(i_div))
         gap_r <= '0;
      else if (gap_r != 8'hff)
         gap_r <= gap_r + 1'b1;
   end

   a_full_rate: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      ($past(i_mode) == CKM_NORMAL && $past(i_mode, 2) == CKM_NORMAL &&
       $past(i_mode, 3) == CKM_NORMAL && $past(i_div) == '0 &&
       $past(i_div, 2) == '0 && $past(i_div, 3) == '0)
      |-> ($changed(o_clk_out) ||
           $past(o_clk_out) != $past(o_clk_out, 2) ||
           $past(o_clk_out, 2) != $past(o_clk_out, 3)))       // RL2
      else $error("full rate output clock missed an edge");
   a_norm_gap: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      gap_r <= 8'(NORM_GAP_MAX))                              // RL3
      else $error("divided output clock edge too late");
endmodule

/* File: design/suac_top.sv */
// top of the suspend aware clock output block with its register port
//
// How it works
// RL1: a 6 MHz reference is multiplied to a 48 MHz internal rate.
// RL2: output clock is derived from 48 MHz, selectable 3 MHz to 48 MHz.
// RL3: four-bit divider field sets the normal output frequency.
// RL4: during suspend the oscillator and pll are switched off.
// RL5: slow clock disable low keeps output running at about 100 kHz.
// RL6: oscillator run bit turns the oscillator on or off.
// RL7: firmware enters suspend by setting then clearing suspend request.
// RL8: suspended status and clock output change about 2 ms after entry.
// RL9: wake-up pulse resumes; about 0.5 ms later status clears, clock runs.
// RL10: slow clock disable high stops the output clock during suspend.
`timescale 1ns/100ps
module suac_top
   import suac_pkg::*;
#(
   parameter int SUSP_CYC = SUSP_DELAY_CYC,
   parameter int RES_CYC  = RES_DELAY_CYC
)
(
   // clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_sys_rst,
   // register port
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [DATA_W-1:0] i_wdata,
   input  wire logic              i_wr,
   input  wire logic              i_rd,
   output logic [DATA_W-1:0]      o_rdata,
   // pins
   input  wire logic              i_device_wakeup_in,
   output logic                   o_programmable_clock_out,
   output logic                   o_suspended,
   output logic                   o_osc_enable,
   output logic                   o_pll_enable
);
   localparam logic [TMR_W-1:0] SUSP_LAST = TMR_W'(SUSP_CYC - 1);
   localparam logic [TMR_W-1:0] RES_LAST  = TMR_W'(RES_CYC - 1);

   typedef enum logic [1:0]
      {ST_RUN, ST_SUSP_WAIT, ST_SUSPENDED, ST_RESUME_WAIT} suac_state_t;

   suac_state_t       state_r;
   suac_state_t       state_nxt;
   logic [TMR_W-1:0]  timer_r;
   logic [TMR_W-1:0]  timer_nxt;
   logic [DIV_W-1:0]  cfg_div_r;
   logic              cfg_osc_r;
   logic              cfg_slow_dis_r;
   logic              mode_susp_r;
   logic              mode_susp_q_r;
   logic              wake_s1_r;
   logic              wake_s2_r;
   logic              wake_s3_r;
   logic              wake_lvl_r;
   logic              susp_r;
   logic              osc_en_r;
   suac_clkmode_t     clk_mode_r;
   suac_clkmode_t     clk_mode_nxt;
   logic [DATA_W-1:0] rdata_r;
   logic [DATA_W-1:0] rdata_nxt;
   logic [DATA_W-1:0] cfg_word;
   logic [DATA_W-1:0] mode_word;
   logic [DATA_W-1:0] sts_word;
   logic              wr_cfg;
   logic              wr_mode;
   logic              susp_fall;
   logic              wake_agree;
   logic              wake_rise;
   logic              in_wait;
   logic              osc_allowed;
   logic              fast_ok;

   // write decode
   assign wr_cfg  = i_wr && (i_addr == REG_HW_CONFIG);
   assign wr_mode = i_wr && (i_addr == REG_DEV_MODE);

   // read words, unused bits read zero
   assign cfg_word  = (DATA_W'(cfg_div_r) << CFG_DIV_LSB)
                    | (DATA_W'(cfg_osc_r) << CFG_OSC_BIT)
                    | (DATA_W'(cfg_slow_dis_r) << CFG_SLOW_BIT);
   assign mode_word = DATA_W'(mode_susp_r) << MODE_SUSP_BIT;
   assign sts_word  = (DATA_W'(susp_r) << STS_SUSP_BIT)
                    | (DATA_W'(osc_en_r) << STS_OSC_BIT)
                    | (DATA_W'(osc_en_r) << STS_PLL_BIT)
                    | (DATA_W'(clk_mode_r == CKM_LAZY) << STS_LAZY_BIT)
                    | (DATA_W'(clk_mode_r == CKM_STOP) << STS_STOP_BIT);
   assign rdata_nxt = !i_rd                   ? '0 :
                      (i_addr == REG_HW_CONFIG) ? cfg_word :
                      (i_addr == REG_DEV_MODE)  ? mode_word :
                      (i_addr == REG_STATUS)    ? sts_word : '0;

   // suspend entry on the clearing edge of the request bit
   assign susp_fall = mode_susp_q_r && !mode_susp_r;         // RL7

   // wake pin counts once the last two sync stages agree
   assign wake_agree = (wake_s2_r == wake_s3_r);
   assign wake_rise  = wake_agree && wake_s3_r && !wake_lvl_r;

   // suspend state machine
   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         ST_RUN:
            if (susp_fall)
               state_nxt = ST_SUSP_WAIT;
         ST_SUSP_WAIT:
            if (wake_rise)
               state_nxt = ST_RUN;
            else if (timer_r == SUSP_LAST)
               state_nxt = ST_SUSPENDED;                      // RL8
         ST_SUSPENDED:
            if (wake_rise)
               state_nxt = ST_RESUME_WAIT;                    // RL9
         ST_RESUME_WAIT:
            if (timer_r == RES_LAST)
               state_nxt = ST_RUN;                            // RL9
      endcase
   end

   // delay timer runs only in the two wait states
   assign in_wait   = (state_r == ST_SUSP_WAIT) ||
                      (state_r == ST_RESUME_WAIT);
   assign timer_nxt = (!in_wait || state_nxt != state_r) ? '0 :
                      timer_r + 1'b1;

   // oscillator and pll off while suspended, restart during resume
   assign osc_allowed = (state_nxt != ST_SUSPENDED);          // RL4
   assign fast_ok     = cfg_osc_r &&
                        (state_nxt == ST_RUN ||
                         state_nxt == ST_SUSP_WAIT);
   assign clk_mode_nxt =
      fast_ok                                  ? CKM_NORMAL :
      (state_nxt == ST_RUN ||
       state_nxt == ST_SUSP_WAIT)              ? CKM_STOP :
      cfg_slow_dis_r                           ? CKM_STOP :   // RL10
                                                 CKM_LAZY;    // RL5

   // register file
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         cfg_div_r      <= CFG_DIV_RST;
         cfg_osc_r      <= CFG_OSC_RST;
         cfg_slow_dis_r <= CFG_SLOW_RST;
         mode_susp_r    <= 1'b0;
         mode_susp_q_r  <= 1'b0;
         rdata_r        <= '0;
      end
      else
      begin
         if (wr_cfg)
         begin
            cfg_div_r      <= i_wdata[CFG_DIV_LSB +: DIV_W];  // RL3
            cfg_osc_r      <= i_wdata[CFG_OSC_BIT];           // RL6
            cfg_slow_dis_r <= i_wdata[CFG_SLOW_BIT];
         end
         if (wr_mode)
            mode_susp_r <= i_wdata[MODE_SUSP_BIT];
         mode_susp_q_r <= mode_susp_r;
         rdata_r       <= rdata_nxt;
      end
   end

   // wake pin synchroniser and filtered level
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         wake_s1_r  <= 1'b0;
         wake_s2_r  <= 1'b0;
         wake_s3_r  <= 1'b0;
         wake_lvl_r <= 1'b0;
      end
      else
      begin
         wake_s1_r  <= i_device_wakeup_in;
         wake_s2_r  <= wake_s1_r;
         wake_s3_r  <= wake_s2_r;
         wake_lvl_r <= wake_agree ? wake_s3_r : wake_lvl_r;
      end
   end

   // state, timer and pin flops
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         state_r    <= ST_RUN;
         timer_r    <= '0;
         susp_r     <= 1'b0;
         osc_en_r   <= 1'b0;
         clk_mode_r <= CKM_STOP;
      end
      else
      begin
         state_r    <= state_nxt;
         timer_r    <= timer_nxt;
         susp_r     <= (state_nxt == ST_SUSPENDED) ||
                       (state_nxt == ST_RESUME_WAIT);         // RL8 RL9
         osc_en_r   <= cfg_osc_r && osc_allowed;              // RL6 RL4
         clk_mode_r <= clk_mode_nxt;
      end
   end

   assign o_rdata      = rdata_r;
   assign o_suspended  = susp_r;
   assign o_osc_enable = osc_en_r;
   assign o_pll_enable = osc_en_r;

   // output clock generator
   suac_clkgen u_clkgen
   (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_mode    (clk_mode_r),
      .i_div     (cfg_div_r),
      .o_clk_out (o_programmable_clock_out)
   );

   // helper: cycles since last slow clock edge
   logic [LAZY_W:0] lazy_gap_r;
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst || clk_mode_r != CKM_LAZY ||
          $changed(o_programmable_clock_out))
         lazy_gap_r <= '0;
      else
         lazy_gap_r <= lazy_gap_r + 1'b1;
   end

   a_osc_off_susp: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      state_r == ST_SUSPENDED |-> !o_osc_enable && !o_pll_enable) // RL4
      else $error("oscillator or pll on while suspended");
   a_osc_bit_ctl: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (state_r == ST_RUN && $past(state_r) == ST_RUN && !$past(i_sys_rst))
      |-> o_osc_enable == $past(cfg_osc_r))                   // RL6
      else $error("oscillator enable does not follow run bit");
   a_susp_start: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (state_r == ST_RUN && susp_fall)
      |=> state_r == ST_SUSP_WAIT && timer_r == '0 && !o_suspended) // RL8
      else $error("suspend wait not started on request clear");
   a_susp_delay: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      $rose(o_suspended) |-> $past(state_r) == ST_SUSP_WAIT &&
      $past(timer_r) == SUSP_LAST)                            // RL8
      else $error("suspended status rose at wrong time");
   a_wake_resume: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (state_r == ST_SUSPENDED && wake_rise)
      |=> state_r == ST_RESUME_WAIT && o_suspended)           // RL9
      else $error("wake pulse did not start resume");
   a_resume_delay: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      $fell(o_suspended) |-> $past(state_r) == ST_RESUME_WAIT &&
      $past(timer_r) == RES_LAST)                             // RL9
      else $error("suspended status cleared at wrong time");
   a_lazy_select: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (state_r == ST_SUSPENDED && !$past(cfg_slow_dis_r))
      |-> clk_mode_r == CKM_LAZY)                             // RL5
      else $error("slow clock not selected in suspend");
   a_lazy_period: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      lazy_gap_r <= (LAZY_W+1)'(LAZY_HALF_CYC))               // RL5
      else $error("slow clock half period too long");
   a_stop_held: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (clk_mode_r == CKM_STOP && $past(clk_mode_r) == CKM_STOP)
      |-> !o_programmable_clock_out)                          // RL10
      else $error("stopped output clock not held low");

   c_suspend: cover property (@(posedge i_clk) $rose(o_suspended));
   c_resume: cover property (@(posedge i_clk) $fell(o_suspended));
   c_lazy: cover property (@(posedge i_clk)
      clk_mode_r == CKM_LAZY && $changed(o_programmable_clock_out));
   c_abort: cover property (@(posedge i_clk)
      state_r == ST_SUSP_WAIT && wake_rise);
endmodule

/* File: verification/suac_far_end.sv */
// far side model: clock consumer counting edges and wake-up pulse source
`timescale 1ns/100ps
module suac_far_end
(
   // clock
   input  wire logic        i_clk,
   // bench control
   input  wire logic        i_clear,
   input  wire logic        i_wake_req,
   // device pins
   input  wire logic        i_clk_out,
   output logic             o_wake,
   output logic [15:0]      o_rises
);
   logic        prev_r     = 1'b0;
   logic [2:0]  wake_cnt_r = 3'h0;
   logic [15:0] rises_r    = 16'h0000;

   // count rising edges of the output clock as the consumer sees them
   always_ff @(posedge i_clk)
   begin
      prev_r <= i_clk_out;
      if (i_clear)
         rises_r <= 16'h0000;
      else if (i_clk_out && !prev_r)
         rises_r <= rises_r + 16'h0001;
   end
   assign o_rises = rises_r;

   // wake pulse four cycles wide, wider than the three flop sampler
   always_ff @(posedge i_clk)
   begin
      if (i_wake_req)
         wake_cnt_r <= 3'h4;
      else if (wake_cnt_r != 3'h0)
         wake_cnt_r <= wake_cnt_r - 3'h1;
   end
   assign o_wake = (wake_cnt_r != 3'h0);
endmodule

/* File: verification/suspend_aware_clock_output_bench.sv */
// self-checking bench for the suspend aware clock output block
`timescale 1ns/100ps
module suspend_aware_clock_output_bench;
   import suac_pkg::*;
   localparam int SUSP = 20;
   localparam int RES  = 10;
   logic              i_clk    = 1'b0;
   logic              i_sys_rst = 1'b1;
   logic [ADDR_W-1:0] i_addr   = 8'h00;
   logic [DATA_W-1:0] i_wdata  = 16'h0000;
   logic              i_wr     = 1'b0;
   logic              i_rd     = 1'b0;
   logic              clear    = 1'b0;
   logic              wake_req = 1'b0;
   logic [DATA_W-1:0] o_rdata;
   logic              wake;
   logic              clk_out;
   logic              o_suspended;
   logic              o_osc_enable;
   logic              o_pll_enable;
   logic [15:0]       rises;
   int                error_cnt = 0;
   int                n_checks  = 0;

   suac_top #(.SUSP_CYC(SUSP), .RES_CYC(RES)) u_suac_top (
      .i_clk                    (i_clk),
      .i_sys_rst                (i_sys_rst),
      .i_addr                   (i_addr),
      .i_wdata                  (i_wdata),
      .i_wr                     (i_wr),
      .i_rd                     (i_rd),
      .o_rdata                  (o_rdata),
      .i_device_wakeup_in       (wake),
      .o_programmable_clock_out (clk_out),
      .o_suspended              (o_suspended),
      .o_osc_enable             (o_osc_enable),
      .o_pll_enable             (o_pll_enable)
   );

   suac_far_end u_suac_far_end (
      .i_clk      (i_clk),
      .i_clear    (clear),
      .i_wake_req (wake_req),
      .i_clk_out  (clk_out),
      .o_wake     (wake),
      .o_rises    (rises)
   );

   // 250 MHz system clock
   initial
   begin
      forever #2 i_clk = ~i_clk;
   end

   task automatic close_out();
      if (error_cnt == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge i_clk);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr    <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      @(posedge i_clk);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd   <= 1'b0;
      #1;
      check(o_rdata, exp);
   endtask

   // count output clock rises over n cycles, expect lo..hi
   task automatic meas(input int n, input int lo, input int hi);
      @(posedge i_clk);
      clear <= 1'b1;
      @(posedge i_clk);
      clear <= 1'b0;
      repeat (n) @(posedge i_clk);
      #1;
      check({15'h0000, (rises >= lo && rises <= hi)}, 16'h0001);
   endtask

   task automatic pins(input logic susp, input logic osc);
      #1;
      check({14'h0000, o_suspended, o_osc_enable}, {14'h0000, susp, osc});
      check({15'h0000, o_pll_enable}, {15'h0000, osc});
   endtask

   task automatic suspend();
      wr(REG_DEV_MODE, 16'h0001);
      wr(REG_DEV_MODE, 16'h0000);
      repeat (SUSP - 2) @(posedge i_clk);
      pins(1'b0, 1'b1);
      repeat (4) @(posedge i_clk);
      pins(1'b1, 1'b0);
   endtask

   task automatic resume();
      @(posedge i_clk);
      wake_req <= 1'b1;
      @(posedge i_clk);
      wake_req <= 1'b0;
      repeat (7) @(posedge i_clk);
      pins(1'b1, 1'b1);
      repeat (RES + 4) @(posedge i_clk);
      pins(1'b0, 1'b1);
   endtask

   // watchdog
   initial
   begin
      repeat (80000) @(posedge i_clk);
      error_cnt++;
      close_out();
   end

   // main sequence
   initial
   begin
      repeat (16) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      rd(REG_HW_CONFIG, 16'h0010);
      rd(REG_DEV_MODE, 16'h0000);
      rd(REG_STATUS, 16'h0006);
      wr(8'h0C, 16'hFFFF);
      rd(8'h0C, 16'h0000);
      rd(REG_HW_CONFIG, 16'h0010);
      // divider settings, 2500 cycles hold 480/(div+1) rises
      for (int d = 0; d < 16; d += 5)
      begin
         wr(REG_HW_CONFIG, 16'h0010 | 16'(d));
         rd(REG_HW_CONFIG, 16'h0010 | 16'(d));
         meas(2500, 480 / (d + 1) - 2, 480 / (d + 1) + 2);
      end
      wr(REG_HW_CONFIG, 16'h000F);
      meas(2500, 0, 0);
      rd(REG_STATUS, 16'h0010);
      wr(REG_HW_CONFIG, 16'h0011);
      rd(REG_STATUS, 16'h0006);
      meas(2500, 238, 242);
      // suspend with the slow clock, then wake
      suspend();
      rd(REG_STATUS, 16'h0009);
      meas(10000, 3, 5);
      resume();
      meas(2500, 238, 242);
      // suspend with the output held stopped
      wr(REG_HW_CONFIG, 16'h0031);
      suspend();
      rd(REG_STATUS, 16'h0011);
      meas(3000, 0, 0);
      #1;
      check({15'h0000, clk_out}, 16'h0000);
      resume();
      meas(2500, 238, 242);
      // wake during the entry wait cancels the suspend
      wr(REG_DEV_MODE, 16'h0001);
      wr(REG_DEV_MODE, 16'h0000);
      @(posedge i_clk);
      wake_req <= 1'b1;
      @(posedge i_clk);
      wake_req <= 1'b0;
      repeat (SUSP + 20) @(posedge i_clk);
      pins(1'b0, 1'b1);
      close_out();
   end
endmodule
